/* File: common/cmc_map.vh */
`ifndef CMC_MAP_VH
`define CMC_MAP_VH

// Register byte addresses
`define CMC_ADDR_W 8
`define CMC_CTRL_ADDR 8'h00
`define CMC_STATUS_ADDR 8'h04

// Control register fields
`define CMC_CTRL_TEMP_PRESENT 0
`define CMC_CTRL_CUTOFF_PRESENT 1
`define CMC_CTRL_RESET 2'h3

// Status register fields
`define CMC_ST_MODE_LSB 0
`define CMC_ST_STAGE_ON 8
`define CMC_ST_FAULT_CUR 9
`define CMC_ST_PROBE_CUR 10
`define CMC_ST_TIMER_CLEAR 11
`define CMC_ST_TIMER_HOLD 12
`define CMC_ST_STAT_A_ON 13
`define CMC_ST_STAT_B_ON 14
`define CMC_ST_PG_ON 15
`define CMC_ST_TERM_EN 16

// AXI responses
`define CMC_RESP_OKAY 2'h0
`define CMC_RESP_DECERR 2'h3

// Timing
`define CMC_CLK_MHZ 10
`define CMC_POR_TIME_US 100
`define CMC_POR_CYCLES (`CMC_POR_TIME_US * `CMC_CLK_MHZ)

`endif

/* File: logic/cmc_delay_counter.v */
`timescale 1ns/1ns
module cmc_delay_counter #(
  parameter WIDTH = 16,
  parameter COUNT = 1000
)
(
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Control
  input wire clear,
  input wire run,
  // Result
  output reg done
);

reg [WIDTH-1:0] count;
localparam [WIDTH-1:0] LAST = COUNT[WIDTH-1:0] - 1'b1;

always @(posedge core_clk or negedge reset_n)
begin
  if (!reset_n)
  begin
    count <= {WIDTH{1'b0}};
    done <= 1'b0;
  end
  else if (clear)
  begin
    count <= {WIDTH{1'b0}};
    done <= 1'b0;
  end
  else if (run && !done)
  begin
    count <= count + 1'b1;
    if (count == LAST)
      done <= 1'b1;
  end
end

endmodule // cmc_delay_counter

/* File: logic/cmc_top.v */
`timescale 1ns/1ns
`include "cmc_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Low charge enable permits charging, high forbids it.
// - Input present with enable high means standby, power stage off.
// - Enable going low starts a fresh charge cycle.
// - Without a pack sensor the pack temperature counts as in range.
// - Standby keeps charging off and clears all timers.
// - Suspend keeps charging off and freezes timers without clearing.
// - Timer fault, termination and short flags arrive latched from outside.
// - Pack reading outside the lower/upper window suspends charging at once.
// - Temperature suspend switches the stage off and keeps timer values.
// - Pack back inside the window resumes charging from the held state.
// - Power-good pulled low only with input present and no overvoltage.
// - Input overvoltage switches the charger off and enters standby.
// - Overvoltage is not latched; operation returns when it clears.
// - Both status outputs are open collector; ON sinks, OFF floats.
// - Termination disabled: never done, show fast or precharge by battery level.
// - Termination disabled by floating timer pin or high cutoff allow.
// - Status: both ON precharge, A only fast, B only done.
// - During power-on delay status shows off and power-good shows absent.
// - Loss of input power enters sleep from any state, stage off.
////////////////////////////////////////////////////////////////////////////////
module cmc_top #(
  parameter POR_CYCLES = `CMC_POR_CYCLES,
  parameter POR_WIDTH = 16
)
(
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Host control
  input wire charge_enable_n,
  input wire cutoff_allow_n,
  // Input supply detection
  input wire input_detected,
  input wire input_overvoltage,
  // Latched flags from detection circuits
  input wire timer_fault,
  input wire termination_done,
  input wire output_short,
  // Pack and die temperature comparators
  input wire pack_temp_below_lower,
  input wire pack_temp_above_upper,
  input wire pack_absent,
  input wire die_overheat,
  // Battery and timer pin sense
  input wire battery_above_precharge,
  input wire timer_pin_floating,
  // Power stage and timer control
  output reg stage_on,
  output reg stage_fault_current,
  output reg stage_probe_current,
  output reg timer_clear,
  output reg timer_hold,
  // Open-collector pins
  output reg input_power_good_n_out,
  output reg input_power_good_n_oe,
  output reg status_out_a_out,
  output reg status_out_a_oe,
  output reg status_out_b_out,
  output reg status_out_b_oe,
  // AXI4-Lite slave
  input wire [`CMC_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`CMC_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// Modes, one-hot

localparam [6:0] M_SLEEP = 7'h01;
localparam [6:0] M_POR = 7'h02;
localparam [6:0] M_STANDBY = 7'h04;
localparam [6:0] M_BEGIN = 7'h08;
localparam [6:0] M_CHARGING = 7'h10;
localparam [6:0] M_SUSPEND = 7'h20;
localparam [6:0] M_HALT = 7'h40;

reg [6:0] mode;
reg [6:0] next_mode;
reg [1:0] ctrl;
reg enable_n_prev;
wire por_done;

////////////////////////////////////////////////////////////////////////////////
// Qualifying conditions

// Sensor-less variant reads as in range
wire temp_ok = !ctrl[`CMC_CTRL_TEMP_PRESENT] ||
  (!pack_temp_below_lower && !pack_temp_above_upper);
wire term_enabled = !timer_pin_floating &&
  !(ctrl[`CMC_CTRL_CUTOFF_PRESENT] && cutoff_allow_n);
wire enable_fall = enable_n_prev && !charge_enable_n;
// Flags are held by the outside detectors; only sampled here
wire any_flag = timer_fault || termination_done || output_short;

always @(posedge core_clk or negedge reset_n)
begin
  if (!reset_n)
    enable_n_prev <= 1'b1;
  else
    enable_n_prev <= charge_enable_n;
end

cmc_delay_counter #(
  .WIDTH(POR_WIDTH),
  .COUNT(POR_CYCLES)
) u_por (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .clear(mode == M_SLEEP),
  .run(mode == M_POR),
  .done(por_done)
);

////////////////////////////////////////////////////////////////////////////////
// Mode decision

always @*
begin
  next_mode = mode;
  case (mode)
    M_SLEEP:
      next_mode = M_POR;
    M_POR:
      if (por_done)
      begin
        if (charge_enable_n || input_overvoltage)
          next_mode = M_STANDBY;
        else
          next_mode = M_BEGIN;
      end
    M_STANDBY:
      if (!charge_enable_n && !input_overvoltage)
        next_mode = M_BEGIN;
    M_BEGIN:
      next_mode = M_CHARGING;
    M_CHARGING:
      if (!temp_ok)
        next_mode = M_SUSPEND;
      else if (any_flag)
        next_mode = M_HALT;
    M_SUSPEND:
      if (temp_ok)
        next_mode = M_CHARGING;
    M_HALT:
      if (!any_flag)
        next_mode = M_CHARGING;
    default:
      next_mode = M_SLEEP;
  endcase
  // Overrides, highest last
  if (mode != M_SLEEP && mode != M_POR)
  begin
    if (charge_enable_n || input_overvoltage)
      next_mode = M_STANDBY;
    else if (enable_fall)
      next_mode = M_BEGIN;
  end
  if (!input_detected)
    next_mode = M_SLEEP;
end

always @(posedge core_clk or negedge reset_n)
begin
  if (!reset_n)
    mode <= M_SLEEP;
  else
    mode <= next_mode;
end

////////////////////////////////////////////////////////////////////////////////
// Power stage, timers and pins

wire active = (next_mode == M_CHARGING) || (next_mode == M_HALT) ||
  (next_mode == M_SUSPEND);
wire precharge = !battery_above_precharge;
// Termination halts the stage but must still be reported as done
wire done_only = termination_done && !timer_fault && !output_short;
wire show_charge = ((next_mode == M_CHARGING) || (next_mode == M_HALT)) &&
  (!any_flag || done_only);
wire show_done = done_only && term_enabled;

always @(posedge core_clk or negedge reset_n)
begin
  if (!reset_n)
  begin
    stage_on <= 1'b0;
    stage_fault_current <= 1'b0;
    stage_probe_current <= 1'b0;
    timer_clear <= 1'b1;
    timer_hold <= 1'b0;
    input_power_good_n_out <= 1'b0;
    input_power_good_n_oe <= 1'b0;
    status_out_a_out <= 1'b0;
    status_out_a_oe <= 1'b0;
    status_out_b_out <= 1'b0;
    status_out_b_oe <= 1'b0;
  end
  else
  begin
    stage_on <= (next_mode == M_CHARGING) && !any_flag && temp_ok &&
      !die_overheat;
    stage_fault_current <= active && timer_fault && !output_short &&
      !termination_done && precharge;
    stage_probe_current <= active && !timer_fault && !output_short &&
      termination_done && pack_absent && !die_overheat;
    // Timers cleared outside charging, halt and suspend; frozen in suspend
    timer_clear <= !active;
    timer_hold <= (next_mode == M_SUSPEND);
    // Power-good sinks only when present without overvoltage
    input_power_good_n_oe <= input_detected && !input_overvoltage &&
      (next_mode != M_SLEEP) && (next_mode != M_POR);
    // Status pins: low drive when ON, released when OFF
    status_out_a_oe <= show_charge && !show_done;
    status_out_b_oe <= show_charge && (show_done || precharge);
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register access

reg aw_held;
reg w_held;
reg [`CMC_ADDR_W-1:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire [31:0] status_word = {15'h0, term_enabled, input_power_good_n_oe,
  status_out_b_oe, status_out_a_oe, timer_hold, timer_clear,
  stage_probe_current, stage_fault_current, stage_on, 1'b0, mode};

always @(posedge core_clk or negedge reset_n)
begin
  if (!reset_n)
  begin
    aw_held <= 1'b0;
    w_held <= 1'b0;
    aw_addr <= 8'h00;
    w_data <= 32'h0000_0000;
    w_strb <= 4'h0;
    ctrl <= `CMC_CTRL_RESET;
    s_axi_awready <= 1'b1;
    s_axi_wready <= 1'b1;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `CMC_RESP_OKAY;
  end
  else
  begin
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid)
    begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == `CMC_CTRL_ADDR)
      begin
        // Variant straps steer the mode logic
        if (w_strb[0])
          ctrl <= w_data[1:0];
        s_axi_bresp <= `CMC_RESP_OKAY;
      end
      else if (aw_addr == `CMC_STATUS_ADDR)
        s_axi_bresp <= `CMC_RESP_OKAY;
      else
        s_axi_bresp <= `CMC_RESP_DECERR;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
  end
end

always @(posedge core_clk or negedge reset_n)
begin
  if (!reset_n)
  begin
    s_axi_arready <= 1'b1;
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0000_0000;
    s_axi_rresp <= `CMC_RESP_OKAY;
  end
  else if (s_axi_arvalid && s_axi_arready)
  begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid <= 1'b1;
    if (s_axi_araddr == `CMC_CTRL_ADDR)
    begin
      s_axi_rdata <= {30'h0, ctrl};
      s_axi_rresp <= `CMC_RESP_OKAY;
    end
    else if (s_axi_araddr == `CMC_STATUS_ADDR)
    begin
      s_axi_rdata <= status_word;
      s_axi_rresp <= `CMC_RESP_OKAY;
    end
    else
    begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CMC_RESP_DECERR;
    end
  end
  else if (s_axi_rvalid && s_axi_rready)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_arready <= 1'b1;
  end
end

endmodule // cmc_top

/* File: test/charger_mode_control_logic_tb.sv */
`timescale 1ns/1ns
`include "cmc_map.vh"
module charger_mode_control_logic_tb;
  reg core_clk = 1'b0;
  reg reset_n = 1'b0;
  reg charge_enable_n, cutoff_allow_n, input_detected, input_overvoltage, timer_fault;
  reg termination_done, output_short, pack_temp_below_lower, pack_temp_above_upper;
  reg pack_absent, die_overheat, battery_above_precharge, timer_pin_floating, busy;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, seed, d;
  reg [3:0] s_axi_wstrb, e;
  reg [1:0] r;
  wire stage_on, stage_fault_current, stage_probe_current, timer_clear, timer_hold;
  wire input_power_good_n_out, input_power_good_n_oe, status_out_a_out, status_out_a_oe;
  wire status_out_b_out, status_out_b_oe, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid, pg_pin, a_pin, b_pin;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer n_fail = 0, tests_run = 0, cyc = 0, i;
  always #50 core_clk = ~core_clk;
  cmc_top #(.POR_CYCLES(8)) dut_u (.core_clk, .reset_n, .charge_enable_n, .cutoff_allow_n,
    .input_detected, .input_overvoltage, .timer_fault, .termination_done, .output_short,
    .pack_temp_below_lower, .pack_temp_above_upper, .pack_absent, .die_overheat,
    .battery_above_precharge, .timer_pin_floating, .stage_on, .stage_fault_current,
    .stage_probe_current, .timer_clear, .timer_hold, .input_power_good_n_out,
    .input_power_good_n_oe, .status_out_a_out, .status_out_a_oe, .status_out_b_out,
    .status_out_b_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  cmc_pin_model pins_u (.pg_oe(input_power_good_n_oe), .a_oe(status_out_a_oe),
    .b_oe(status_out_b_oe), .pg_pin, .a_pin, .b_pin);
  ////////////////////////////////////////
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [31:0] g, input [31:0] x);
    begin
      tests_run = tests_run + 1;
      if (g !== x)
      begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      busy = 1'b1;
      while (busy)
      begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
        begin
          r = s_axi_bresp;
          s_axi_bready <= 1'b0;
          busy = 1'b0;
        end
      end
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      busy = 1'b1;
      while (busy)
      begin
        @(posedge core_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid)
        begin
          d = s_axi_rdata;
          r = s_axi_rresp;
          s_axi_rready <= 1'b0;
          busy = 1'b0;
        end
      end
    end
  endtask
  // One condition at a time; overlapping causes are resolved by the fixed mode priority and overrides
  task vec(input [3:0] ev);
    begin
      @(posedge core_clk);
      seed = xs(seed);
      charge_enable_n <= (ev == 1);
      input_overvoltage <= (ev == 2);
      timer_fault <= (ev == 3);
      termination_done <= (ev == 4);
      output_short <= (ev == 5);
      pack_temp_below_lower <= (ev == 6);
      pack_temp_above_upper <= (ev == 7);
      die_overheat <= (ev == 8);
      battery_above_precharge <= seed[0];
      pack_absent <= seed[1];
      repeat (4) @(posedge core_clk);
      chk(stage_on, ev == 0);
      chk(a_pin, !(ev == 0 || ev == 8));
      chk(b_pin, !(((ev == 0 || ev == 8) && !seed[0]) || ev == 4));
      chk(stage_fault_current, ev == 3 && !seed[0]);
      chk(stage_probe_current, ev == 4 && seed[1]);
      chk(timer_hold, ev == 6 || ev == 7);
      chk(pg_pin, ev == 2);
      if (ev == 1 || ev == 2) chk(timer_clear, 1);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  initial
  begin
    {charge_enable_n, input_detected, battery_above_precharge, s_axi_wstrb} = 7'h7f;
    {cutoff_allow_n, input_overvoltage, timer_fault, termination_done, output_short} = 5'h0;
    {pack_temp_below_lower, pack_temp_above_upper, pack_absent, die_overheat} = 4'h0;
    {timer_pin_floating, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
    seed = 32'h0000_7dc7;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (14) @(posedge core_clk);
    rd(`CMC_CTRL_ADDR);
    chk(d, `CMC_CTRL_RESET);
    rd(`CMC_STATUS_ADDR);
    chk(d[6:0], 7'h04);
    chk(d[16], 1);
    chk({input_power_good_n_out, status_out_a_out, status_out_b_out}, 3'h0);
    $display("power-up test done");
    for (i = 0; i < 9; i = i + 1)
    begin
      vec(i[3:0]);
      vec(4'h0);
    end
    for (i = 0; i < 30; i = i + 1)
    begin
      seed = xs(seed);
      e = 4'(seed % 32'd9);
      vec(e);
      vec(4'h0);
    end
    $display("mode test done");
    cutoff_allow_n <= 1'b1;
    rd(`CMC_STATUS_ADDR);
    chk(d[16], 0);
    cutoff_allow_n <= 1'b0;
    timer_pin_floating <= 1'b1;
    rd(`CMC_STATUS_ADDR);
    chk(d[16], 0);
    timer_pin_floating <= 1'b0;
    wr(`CMC_CTRL_ADDR, 32'h2);
    chk(r, `CMC_RESP_OKAY);
    pack_temp_below_lower <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(stage_on, 1);
    wr(`CMC_CTRL_ADDR, `CMC_CTRL_RESET);
    wr(`CMC_STATUS_ADDR, 32'h0);
    chk(r, `CMC_RESP_OKAY);
    chk(stage_on, 0);
    rd(8'h10);
    chk(r, `CMC_RESP_DECERR);
    chk(d, 32'h0);
    vec(4'h0);
    $display("register test done");
    input_detected <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({stage_on, a_pin, pg_pin}, 3'h3);
    input_detected <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk({a_pin, pg_pin}, 2'h3);
    repeat (10) @(posedge core_clk);
    chk({stage_on, pg_pin}, 2'h2);
    $display("sleep test done");
    complete_run;
  end
endmodule // charger_mode_control_logic_tb

/* File: test/cmc_pin_model.sv */
`timescale 1ns/1ns
module cmc_pin_model (
  // Transistor enables
  input wire pg_oe,
  input wire a_oe,
  input wire b_oe,
  // Pulled-up pins
  output wire pg_pin,
  output wire a_pin,
  output wire b_pin
);
  // Pull-ups: a pin reads low only while its transistor sinks
  assign pg_pin = pg_oe ? 1'b0 : 1'b1;
  assign a_pin = a_oe ? 1'b0 : 1'b1;
  assign b_pin = b_oe ? 1'b0 : 1'b1;
endmodule // cmc_pin_model

/* File: test/cmc_props.sv */
`timescale 1ns/1ns
module cmc_props (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Design inputs
  input wire charge_enable_n,
  input wire input_detected,
  input wire input_overvoltage,
  input wire timer_fault,
  input wire termination_done,
  input wire output_short,
  input wire die_overheat,
  input wire battery_above_precharge,
  input wire timer_pin_floating,
  // Design outputs
  input wire stage_on,
  input wire stage_fault_current,
  input wire timer_hold,
  input wire input_power_good_n_oe,
  input wire status_out_a_oe,
  input wire status_out_b_oe
);
  // Pack window is left out: it depends on the control register
  wire ok_in = !charge_enable_n && input_detected && !input_overvoltage && !timer_fault
    && !termination_done && !output_short && !die_overheat;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_sleep;
    !input_detected |=> !stage_on && !status_out_a_oe && !status_out_b_oe;
  endproperty
  a_sleep: assert property (p_sleep) else $error("on without input");
  property p_pg;
    !input_detected || input_overvoltage |=> !input_power_good_n_oe;
  endproperty
  a_pg: assert property (p_pg) else $error("power good wrong");
  property p_stby;
    input_detected && charge_enable_n |=> !stage_on && !status_out_a_oe;
  endproperty
  a_stby: assert property (p_stby) else $error("standby not off");
  property p_full;
    stage_on |-> $past(ok_in);
  endproperty
  a_full: assert property (p_full) else $error("stage on unqualified");
  property p_hold;
    timer_hold |-> !stage_on && !status_out_a_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("suspend not off");
  property p_fault;
    stage_fault_current |-> !stage_on && $past(timer_fault) && !$past(output_short);
  endproperty
  a_fault: assert property (p_fault) else $error("bad fault current");
  property p_pre;
    status_out_a_oe && status_out_b_oe |-> !$past(battery_above_precharge);
  endproperty
  a_pre: assert property (p_pre) else $error("bad precharge");
  property p_por;
    $rose(input_detected) |=> (!input_power_good_n_oe) [*8];
  endproperty
  a_por: assert property (p_por) else $error("power good early");
  property p_done;
    status_out_b_oe && !status_out_a_oe |-> $past(termination_done);
  endproperty
  a_done: assert property (p_done) else $error("done without termination");
  property p_nodone;
    status_out_b_oe && $past(timer_pin_floating) |-> status_out_a_oe;
  endproperty
  a_nodone: assert property (p_nodone) else $error("done while disabled");
  property p_ovp;
    input_detected && input_overvoltage |=> !stage_on && !status_out_a_oe && !status_out_b_oe;
  endproperty
  a_ovp: assert property (p_ovp) else $error("on during overvoltage");
  c_on: cover property (stage_on);
  c_done: cover property (status_out_b_oe && !status_out_a_oe);
  c_fault: cover property (stage_fault_current);
  c_hold: cover property (timer_hold);
endmodule // cmc_props
////////////////////////////////////////
bind cmc_top cmc_props chk_u (.core_clk, .reset_n, .charge_enable_n, .input_detected,
  .input_overvoltage, .timer_fault, .termination_done, .output_short, .die_overheat,
  .battery_above_precharge, .timer_pin_floating, .stage_on, .stage_fault_current, .timer_hold,
  .input_power_good_n_oe, .status_out_a_oe, .status_out_b_oe);
